//--- include/ifts_pkg.sv
// Package with constants, types and register map of the interval flag timer.
package ifts_pkg;

    // ****************************************************************
    // Clock and interval timing
    // ****************************************************************
    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned MS_PER_S      = 1000;
    localparam int unsigned PERIOD_MS_10  = 100;
    localparam int unsigned PERIOD_MS_20  = 50;
    localparam int unsigned PERIOD_MS_50  = 20;
    localparam int unsigned PERIOD_MS_100 = 10;
    // Half a period in clock cycles, since each train toggles twice per period.
    localparam int unsigned HALF_10  = CLK_HZ / MS_PER_S * PERIOD_MS_10 / 2;
    localparam int unsigned HALF_20  = CLK_HZ / MS_PER_S * PERIOD_MS_20 / 2;
    localparam int unsigned HALF_50  = CLK_HZ / MS_PER_S * PERIOD_MS_50 / 2;
    localparam int unsigned HALF_100 = CLK_HZ / MS_PER_S * PERIOD_MS_100 / 2;
    localparam int unsigned CNT_W    = 20;
    localparam int unsigned NUM_TR   = 4;
    // Phase step between trains, far below the shortest period.
    localparam logic [CNT_W-1:0] PHASE_STEP = 20'h00010;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int unsigned AW = 8;
    localparam int unsigned DW = 4;
    localparam logic [AW-1:0] ADDR_DELAY  = 8'h06;
    localparam logic [AW-1:0] ADDR_CARRY  = 8'h17;
    localparam logic [AW-1:0] ADDR_SELECT = 8'h18;
    localparam logic [AW-1:0] ADDR_STATUS = 8'h20;
    localparam logic [AW-1:0] ADDR_MASK   = 8'h21;
    localparam logic [DW-1:0] DATA_ZERO   = 4'h0;
    localparam logic [1:0]    SEL_RESET   = 2'h0;
    localparam logic [DW-1:0] DELAY_RESET = 4'h0;
    localparam logic [15:0]   START_ADDR  = 16'h0000;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0]
    {
        SEL_10HZ  = 2'b00,
        SEL_20HZ  = 2'b01,
        SEL_50HZ  = 2'b10,
        SEL_100HZ = 2'b11
    } ifts_sel_t;

    typedef enum logic [1:0]
    {
        CE_IDLE = 2'b00,
        CE_WAIT = 2'b01,
        CE_FIRE = 2'b10
    } ifts_ce_state_t;

    typedef enum logic [0:0]
    {
        POR_HOLD = 1'b0,
        POR_RUN  = 1'b1
    } ifts_por_state_t;

    // Interrupt sources; status and mask share this layout.
    typedef struct packed
    {
        logic [1:0] spare;
        logic       ceReset;
        logic       flagSet;
    } ifts_evt_t;

endpackage

//--- core/ifts_train_gen.sv
// Four free-running interval pulse trains divided from the clock.
`timescale 1ns/1ps

module ifts_train_gen
#(
    parameter logic [ifts_pkg::NUM_TR-1:0][ifts_pkg::CNT_W-1:0] HALF = '0
)
(
    input  wire logic                        ref_clk,
    input  wire logic                        rst,
    output logic     [ifts_pkg::NUM_TR-1:0]  trains
);

    // ****************************************************************
    // One divider per train
    // ****************************************************************
    genvar i;
    generate
        for (i = 0; i < ifts_pkg::NUM_TR; i++)
        begin : g_train
            logic [ifts_pkg::CNT_W-1:0] cnt_r;
            logic                       lvl_r;

            // Trains never restart each other; a preload skews their phases.
            always_ff @(posedge ref_clk or posedge rst)
            begin
                if (rst)
                begin
                    cnt_r <= ifts_pkg::CNT_W'(i) * ifts_pkg::PHASE_STEP;
                    lvl_r <= 1'b0;
                end
                else if (cnt_r >= HALF[i] - 1'b1)
                begin
                    cnt_r <= '0;
                    lvl_r <= ~lvl_r;
                end
                else
                begin
                    cnt_r <= cnt_r + 1'b1;
                end
            end

            assign trains[i] = lvl_r;
        end
    endgenerate

endmodule

//--- core/ifts_timer.sv
// Interval timer with read-to-clear carry flag and pin-triggered reset sync.
`timescale 1ns/1ps

// Overview of operation
// - Four independent trains; select only picks one.
// - Selected train rising sets flag; falling keeps it.
// - Trains skewed in phase; reselection may set early.
// - Flag cleared at power-on, armed by first read or pin reset.
// - Reading flag returns it and clears it.
// - Pin reset waits for selected rising edge after delay count.
// - Pin reset sets flag and pulses processor reset.
// - Power-on start at 0000H on 10 Hz rise.
// - Reset-delay carry counter at address 06H.
// - Trains divided down from system clock.
// - Flag reads one after clock stop instruction.
// - Coincident set beats read; a read defers pin reset to next edge.
module ifts_timer
#(
    parameter logic [ifts_pkg::CNT_W-1:0] HALF_CYC_10  = ifts_pkg::CNT_W'(ifts_pkg::HALF_10),
    parameter logic [ifts_pkg::CNT_W-1:0] HALF_CYC_20  = ifts_pkg::CNT_W'(ifts_pkg::HALF_20),
    parameter logic [ifts_pkg::CNT_W-1:0] HALF_CYC_50  = ifts_pkg::CNT_W'(ifts_pkg::HALF_50),
    parameter logic [ifts_pkg::CNT_W-1:0] HALF_CYC_100 = ifts_pkg::CNT_W'(ifts_pkg::HALF_100)
)
(
    input  wire logic                        ref_clk,
    input  wire logic                        rst,
    input  wire logic [ifts_pkg::AW-1:0]     regAddr,
    input  wire logic [ifts_pkg::DW-1:0]     regWdata,
    input  wire logic                        regWr,
    input  wire logic                        regRd,
    output logic      [ifts_pkg::DW-1:0]     regRdata,
    input  wire logic                        standbyRelease,
    input  wire logic                        clockStopExec,
    output logic                             cpuResetHold,
    output logic      [15:0]                 startAddr,
    output logic                             irq
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [ifts_pkg::NUM_TR-1:0]    trains;
    logic [1:0]                     select_r;
    logic                           selPrev_r;
    logic                           tenPrev_r;
    logic                           selNow;
    logic                           selRise;
    logic                           tenRise;
    logic                           carry_r;
    logic                           armed_r;
    logic                           pinPrev_r;
    logic                           pinRise;
    logic [ifts_pkg::DW-1:0]        delayLoad_r;
    logic [ifts_pkg::DW-1:0]        delayCnt_r;
    ifts_pkg::ifts_ce_state_t       ceState_r;
    ifts_pkg::ifts_ce_state_t       ceState_nxt;
    ifts_pkg::ifts_por_state_t      porState_r;
    logic                           ceFire;
    logic                           rdCarry;
    logic                           setEdge;
    ifts_pkg::ifts_evt_t            status_r;
    ifts_pkg::ifts_evt_t            mask_r;
    ifts_pkg::ifts_evt_t            events;
    ifts_pkg::ifts_evt_t            wrClear;
    logic                           cpuResetHold_r;
    logic [ifts_pkg::DW-1:0]        regRdata_r;
    logic [ifts_pkg::DW-1:0]        rdValue;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic trainOf
    (
        input logic [ifts_pkg::NUM_TR-1:0] tr,
        input logic [1:0]                  sel
    );
        logic bit_v;
        bit_v = 1'b0;
        case (sel)
            ifts_pkg::SEL_10HZ:  bit_v = tr[0];
            ifts_pkg::SEL_20HZ:  bit_v = tr[1];
            ifts_pkg::SEL_50HZ:  bit_v = tr[2];
            default:             bit_v = tr[3];
        endcase
        return bit_v;
    endfunction

    // ****************************************************************
    // Pulse trains
    // ****************************************************************
    ifts_train_gen
    #(
        .HALF ({HALF_CYC_100, HALF_CYC_50, HALF_CYC_20, HALF_CYC_10})
    )
    u_trains
    (
        .ref_clk (ref_clk),
        .rst     (rst),
        .trains  (trains)
    );

    // The mux output is edge-detected, so a reselection from a low train to a
    // high train counts as a rising edge, while one that lands low does not.
    assign selNow  = trainOf(trains, select_r);
    assign selRise = selNow & ~selPrev_r;
    assign tenRise = trainOf(trains, ifts_pkg::SEL_10HZ) & ~tenPrev_r;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            selPrev_r <= 1'b0;
            tenPrev_r <= 1'b0;
        end
        else
        begin
            selPrev_r <= selNow;
            tenPrev_r <= trainOf(trains, ifts_pkg::SEL_10HZ);
        end
    end

    // ****************************************************************
    // Register decode
    // ****************************************************************
    assign rdCarry = regRd && (regAddr == ifts_pkg::ADDR_CARRY);

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            select_r    <= ifts_pkg::SEL_RESET;
            delayLoad_r <= ifts_pkg::DELAY_RESET;
            mask_r      <= '0;
        end
        else if (regWr)
        begin
            if (regAddr == ifts_pkg::ADDR_SELECT)
            begin
                select_r <= regWdata[1:0];
            end
            else if (regAddr == ifts_pkg::ADDR_DELAY)
            begin
                delayLoad_r <= regWdata;
            end
            else if (regAddr == ifts_pkg::ADDR_MASK)
            begin
                mask_r <= regWdata;
            end
        end
    end

    always_comb
    begin
        rdValue = ifts_pkg::DATA_ZERO;
        if (regAddr == ifts_pkg::ADDR_CARRY)
        begin
            rdValue = {3'h0, carry_r};
        end
        else if (regAddr == ifts_pkg::ADDR_SELECT)
        begin
            rdValue = {2'h0, select_r};
        end
        else if (regAddr == ifts_pkg::ADDR_DELAY)
        begin
            rdValue = delayCnt_r;
        end
        else if (regAddr == ifts_pkg::ADDR_STATUS)
        begin
            rdValue = status_r;
        end
        else if (regAddr == ifts_pkg::ADDR_MASK)
        begin
            rdValue = mask_r;
        end
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            regRdata_r <= ifts_pkg::DATA_ZERO;
        end
        else if (regRd)
        begin
            regRdata_r <= rdValue;
        end
        else
        begin
            regRdata_r <= ifts_pkg::DATA_ZERO;
        end
    end

    assign regRdata = regRdata_r;

    // ****************************************************************
    // Carry flag
    // ****************************************************************
    // Until the first read the interval edges leave the flag clear, which lets software tell
    // a power-on start from a pin-triggered one.
    assign setEdge = armed_r & selRise;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            armed_r <= 1'b0;
        end
        else if (rdCarry || ceFire)
        begin
            armed_r <= 1'b1;
        end
    end

    // A set in the cycle of a read wins; the read still returns the old value.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            carry_r <= 1'b0;
        end
        else if (ceFire || clockStopExec)
        begin
            carry_r <= 1'b1;
        end
        else if (setEdge)
        begin
            carry_r <= 1'b1;
        end
        else if (rdCarry)
        begin
            carry_r <= 1'b0;
        end
    end

    // ****************************************************************
    // Pin-triggered reset
    // ****************************************************************
    assign pinRise = standbyRelease & ~pinPrev_r;

    // A read on the deciding edge defers the reset to the next edge, so a
    // poll loop locked to the interval can hold the reset off forever.
    assign ceFire = (ceState_r == ifts_pkg::CE_WAIT) && selRise && !rdCarry
                    && (delayCnt_r == ifts_pkg::DELAY_RESET);

    always_comb
    begin
        ceState_nxt = ceState_r;
        case (ceState_r)
            ifts_pkg::CE_IDLE:
            begin
                if (pinRise)
                begin
                    ceState_nxt = ifts_pkg::CE_WAIT;
                end
            end
            ifts_pkg::CE_WAIT:
            begin
                if (ceFire)
                begin
                    ceState_nxt = ifts_pkg::CE_FIRE;
                end
            end
            default:
            begin
                ceState_nxt = ifts_pkg::CE_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ceState_r <= ifts_pkg::CE_IDLE;
            pinPrev_r <= 1'b0;
        end
        else
        begin
            ceState_r <= ceState_nxt;
            pinPrev_r <= standbyRelease;
        end
    end

    // The delay counter loads on the pin edge and counts selected rises.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            delayCnt_r <= ifts_pkg::DELAY_RESET;
        end
        else if (ceState_r == ifts_pkg::CE_IDLE && pinRise)
        begin
            delayCnt_r <= delayLoad_r;
        end
        else if (ceState_r == ifts_pkg::CE_WAIT && selRise && !rdCarry
                 && delayCnt_r != ifts_pkg::DELAY_RESET)
        begin
            delayCnt_r <= delayCnt_r - 1'b1;
        end
    end

    // ****************************************************************
    // Processor start control
    // ****************************************************************
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            porState_r <= ifts_pkg::POR_HOLD;
        end
        else if (porState_r == ifts_pkg::POR_HOLD && tenRise)
        begin
            porState_r <= ifts_pkg::POR_RUN;
        end
    end

    // The processor is held until the first 10 Hz rise after power-on and
    // pulsed for one cycle when the pin-triggered reset fires.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            cpuResetHold_r <= 1'b1;
        end
        else if (ceFire)
        begin
            cpuResetHold_r <= 1'b1;
        end
        else if (porState_r == ifts_pkg::POR_HOLD)
        begin
            cpuResetHold_r <= ~tenRise;
        end
        else
        begin
            cpuResetHold_r <= 1'b0;
        end
    end

    assign cpuResetHold = cpuResetHold_r;
    assign startAddr    = ifts_pkg::START_ADDR;

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    always_comb
    begin
        events         = '0;
        events.flagSet = setEdge;
        events.ceReset = ceFire;
        wrClear        = '0;
        if (regWr && regAddr == ifts_pkg::ADDR_STATUS)
        begin
            wrClear = regWdata;
        end
    end

    // Sticky bits: a new event wins over a write-one clear in the same cycle.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            status_r <= '0;
        end
        else
        begin
            status_r <= (status_r & ~wrClear) | events;
        end
    end

    assign irq = |(status_r & mask_r);

endmodule

//--- bench/ifts_timer_asserts.sv
// Port-level checker for the interval flag timer.
`timescale 1ns/1ps

module ifts_timer_asserts
#(
    parameter logic [ifts_pkg::CNT_W-1:0] HALF_CYC_10 = 20'h7A120
)
(
    input wire logic                    ref_clk,
    input wire logic                    rst,
    input wire logic [ifts_pkg::AW-1:0] regAddr,
    input wire logic                    regRd,
    input wire logic [ifts_pkg::DW-1:0] regRdata,
    input wire logic                    standbyRelease,
    input wire logic                    clockStopExec,
    input wire logic                    cpuResetHold,
    input wire logic [15:0]             startAddr
);
    // The 10 Hz train has no skew, so its first rise lands half a period after reset.
    localparam int HOLD_MAX = 2 * int'(HALF_CYC_10) + 68;
    wire carryRd;
    int  holdCnt_r;

    assign carryRd = regRd && (regAddr == ifts_pkg::ADDR_CARRY);

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            holdCnt_r <= 0;
        else if (cpuResetHold)
            holdCnt_r <= holdCnt_r + 1;
        else
            holdCnt_r <= 0;
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    AST_START_ADDR: assert property (startAddr == 16'h0000)
        else $error("start address is not zero");
    AST_HOLD_LEN: assert property (holdCnt_r <= HOLD_MAX)
        else $error("processor hold lasts too long");
    AST_RDATA_IDLE: assert property (!$past(regRd) |-> regRdata == 4'h0)
        else $error("read data outside its slot");
    AST_FLAG_BITS: assert property (carryRd |=> regRdata[3:1] == 3'h0)
        else $error("carry read has upper bits set");
    AST_PIN_LATE: assert property ($rose(standbyRelease) |=> !cpuResetHold)
        else $error("pin reset applied at once");
    AST_HOLD_PULSE: assert property ($rose(cpuResetHold) |=> !cpuResetHold)
        else $error("pin reset pulse longer than one cycle");
    AST_PIN_DEFER: assert property ($rose(cpuResetHold) |-> !$past(carryRd))
        else $error("pin reset fired on an edge with a carry read");
    AST_PIN_FLAG: assert property ($rose(cpuResetHold) ##1 carryRd |=> regRdata == 4'h1)
        else $error("carry flag not set by pin reset");
    AST_CLKSTOP: assert property (clockStopExec ##2 carryRd |=> regRdata == 4'h1)
        else $error("carry flag not set by clock stop");
endmodule

bind ifts_timer ifts_timer_asserts
#(
    .HALF_CYC_10(HALF_CYC_10)
)
u_check
(
    .ref_clk(ref_clk),
    .rst(rst),
    .regAddr(regAddr),
    .regRd(regRd),
    .regRdata(regRdata),
    .standbyRelease(standbyRelease),
    .clockStopExec(clockStopExec),
    .cpuResetHold(cpuResetHold),
    .startAddr(startAddr)
);

//--- bench/ifts_sw_model.sv
// Model of the processor software that reaches the timer registers.
`timescale 1ns/1ps

module ifts_sw_model
(
    input wire logic                    ref_clk,
    input wire logic [ifts_pkg::DW-1:0] regRdata,
    output logic     [ifts_pkg::AW-1:0] regAddr,
    output logic     [ifts_pkg::DW-1:0] regWdata,
    output logic                        regWr,
    output logic                        regRd
);
    int seed = 35489;

    initial
    begin
        regAddr = 8'h00;
        regWdata = 4'h0;
        regWr = 1'b0;
        regRd = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [3:0] d);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask

    // Writes a random nibble and hands it back to the bench model.
    task automatic wr_rand(input logic [7:0] a, output logic [3:0] d);
        d = 4'($random(seed));
        wr(a, d);
    endtask

    task automatic rd(input logic [7:0] a, output logic [3:0] d);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask

    // Back-to-back carry reads, one in every cycle.
    task automatic hammer(input int n);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= ifts_pkg::ADDR_CARRY;
        repeat (n) @(posedge ref_clk);
        regRd <= 1'b0;
    endtask

    // Polls the flag with a random gap that stays far below the shortest interval.
    task automatic poll(input int cycles, output int sets);
        int t;
        int gap;
        logic [3:0] v;
        sets = 0;
        t = 0;
        while (t < cycles)
        begin
            rd(ifts_pkg::ADDR_CARRY, v);
            if (v[0] === 1'b1)
                sets++;
            gap = 2 + ($random(seed) & 7);
            repeat (gap) @(posedge ref_clk);
            t += gap + 2;
        end
    endtask
endmodule

//--- bench/ifts_timer_tb_top.sv
// Self-checking testbench of the interval flag timer.
`timescale 1ns/1ps

module ifts_timer_tb_top;
    logic       ref_clk;
    logic       rst;
    logic       standbyRelease;
    logic       clockStopExec;
    logic [7:0] regAddr;
    logic [3:0] regWdata;
    logic [3:0] regRdata;
    logic       regWr;
    logic       regRd;
    logic       cpuResetHold;
    logic       irq;
    logic [15:0] startAddr;
    logic [3:0] d;
    logic [3:0] expQ[$];
    int         badCount;
    int         checkCount;
    int         n;
    int         t;
    int         h;
    int         s;
    int         halfCyc[4] = '{400, 200, 80, 40};
    logic [7:0] rstAddr[5] = '{8'h18, 8'h21, 8'h06, 8'h20, 8'h3F};

    ifts_timer
    #(
        .HALF_CYC_10(20'h00190),
        .HALF_CYC_20(20'h000C8),
        .HALF_CYC_50(20'h00050),
        .HALF_CYC_100(20'h00028)
    )
    uut
    (
        .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .standbyRelease(standbyRelease), .clockStopExec(clockStopExec),
        .cpuResetHold(cpuResetHold), .startAddr(startAddr), .irq(irq)
    );

    ifts_sw_model sw
    (
        .ref_clk(ref_clk), .regRdata(regRdata), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd)
    );

    // ****************************************************************
    // Checking and closing
    // ****************************************************************
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checkCount++;
        if (got !== exp)
        begin
            badCount++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic rng(input string nm, input int lo, input int hi, input int got);
        checkCount++;
        if (got < lo || got > hi)
        begin
            badCount++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
        end
    endtask

    task automatic finishTest();
        if (badCount == 0 && checkCount > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic raisePin();
        @(posedge ref_clk);
        standbyRelease <= 1'b1;
    endtask

    // Waits for the pin reset pulse, then reads the carry flag at once.
    task automatic waitHold(output int c);
        logic [3:0] v;
        c = 0;
        do
        begin
            @(posedge ref_clk);
            #1 c++;
        end
        while (cpuResetHold !== 1'b1 && c < 400);
        sw.rd(ifts_pkg::ADDR_CARRY, v);
        chk("pinFlag", 16'h0001, v);
        @(posedge ref_clk);
        standbyRelease <= 1'b0;
    endtask

    // ****************************************************************
    // Stimulus
    // ****************************************************************
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    initial
    begin
        repeat (40000) @(posedge ref_clk);
        badCount++;
        finishTest();
    end

    initial
    begin
        badCount = 0;
        checkCount = 0;
        rst = 1'b1;
        standbyRelease = 1'b0;
        clockStopExec = 1'b0;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        t = 0;
        while (cpuResetHold !== 1'b0 && t < 2000)
        begin
            @(posedge ref_clk);
            #1 t++;
        end
        rng("powerOnHold", 1, 870, t);
        chk("startAddr", 16'h0000, startAddr);
        foreach (rstAddr[i])
        begin
            sw.rd(rstAddr[i], d);
            chk("resetValue", 16'h0000, d);
        end
        repeat (1600) @(posedge ref_clk);
        sw.rd(ifts_pkg::ADDR_CARRY, d);
        chk("carryDisarmed", 16'h0000, d);
        repeat (1600) @(posedge ref_clk);
        sw.rd(ifts_pkg::ADDR_CARRY, d);
        chk("carryArmed", 16'h0001, d);
        sw.rd(ifts_pkg::ADDR_CARRY, d);
        chk("carryCleared", 16'h0000, d);
        for (s = 0; s < 4; s++)
        begin
            sw.wr(ifts_pkg::ADDR_SELECT, 4'(s));
            sw.rd(ifts_pkg::ADDR_SELECT, d);
            chk("select", 16'(s), d);
            // An early set after reselection is dropped before counting.
            sw.rd(ifts_pkg::ADDR_CARRY, d);
            sw.poll(16 * halfCyc[s], n);
            rng("setCount", 7, 9, n);
        end
        sw.rd(ifts_pkg::ADDR_CARRY, d);
        raisePin();
        waitHold(t);
        rng("pinDelay0", 2, 84, t);
        sw.wr(ifts_pkg::ADDR_DELAY, 4'h1);
        raisePin();
        waitHold(t);
        rng("pinDelay1", 81, 166, t);
        sw.wr(ifts_pkg::ADDR_DELAY, 4'h0);
        raisePin();
        h = 0;
        fork
            sw.hammer(240);
            repeat (240)
            begin
                @(posedge ref_clk);
                #1 if (cpuResetHold === 1'b1) h++;
            end
        join
        rng("heldByRead", 0, 0, h);
        waitHold(t);
        rng("afterRead", 1, 84, t);
        sw.wr(ifts_pkg::ADDR_SELECT, 4'h0);
        sw.rd(ifts_pkg::ADDR_CARRY, d);
        @(posedge ref_clk);
        clockStopExec <= 1'b1;
        @(posedge ref_clk);
        clockStopExec <= 1'b0;
        sw.rd(ifts_pkg::ADDR_CARRY, d);
        chk("clockStop", 16'h0001, d);
        // Random mask values pass through a queue that models the mask register.
        repeat (4)
        begin
            sw.wr_rand(ifts_pkg::ADDR_MASK, d);
            expQ.push_back(d);
            sw.rd(ifts_pkg::ADDR_MASK, d);
            chk("maskRand", 16'(expQ.pop_front()), d);
        end
        sw.wr(ifts_pkg::ADDR_MASK, 4'h0);
        @(posedge ref_clk);
        #1 chk("irqMasked", 16'h0000, irq);
        sw.wr(ifts_pkg::ADDR_MASK, 4'h3);
        @(posedge ref_clk);
        #1 chk("irqRaised", 16'h0001, irq);
        sw.rd(ifts_pkg::ADDR_MASK, d);
        chk("mask", 16'h0003, d);
        sw.wr(ifts_pkg::ADDR_STATUS, 4'h3);
        @(posedge ref_clk);
        #1 chk("irqCleared", 16'h0000, irq);
        finishTest();
    end
endmodule
